// ---- rtl/sadc_cfg.svh ----
// Constants of the serial converter control block
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// =====================================================
// Widths and counts
`define SADC_RES_BITS 8
`define SADC_IDX_BITS 3
`define SADC_FIFO_DEPTH 4
`define SADC_SYNC_STAGES 2

// =====================================================
// Bit positions of synchronised pin inputs
`define SADC_PIN_SCLK 0
`define SADC_PIN_SEL 1
`define SADC_PIN_DIN 2
`define SADC_PIN_COUNT 3

// =====================================================
// Reset values and index load values
`define SADC_RESULT_RST 8'h00
`define SADC_IDX_MSB 3'h7
`define SADC_IDX_LSB_FIRST 3'h1
// Select pin idles high, the other pins idle low
`define SADC_PIN_RST 3'h2
// Steering of the reset configuration: differential, channel 0 positive
`define SADC_MUX_RST 3'h1

`endif

// ---- rtl/sadc_core.sv ----
// Serial control and result sequencer of an 8-bit successive-approximation converter
`include "sadc_cfg.svh"

module sadc_core #(
    parameter int RES_BITS = `SADC_RES_BITS,
    parameter int FIFO_DEPTH = `SADC_FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    // Serial pins, asynchronous to clock_i
    input wire logic serial_clk_i,
    input wire logic sel_n_i,
    input wire logic serial_cmd_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_n_o,
    // Analog front end
    input wire logic cmp_i,
    output logic [RES_BITS-1:0] dac_code_o,
    output sadc_pkg::sadc_mux_type mux_o,
    output logic sample_o,
    output logic low_power_o,
    // Parallel result stream
    output logic result_valid_o,
    input wire logic result_ready_i,
    output logic [RES_BITS-1:0] result_o,
    output logic result_fifo_ready_o
);
    localparam int IW = `SADC_IDX_BITS;

    initial begin
        if (RES_BITS != (1 << IW)) begin
            $error("sadc_core: RES_BITS must equal 2**SADC_IDX_BITS");
        end
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin
            $error("sadc_core: FIFO_DEPTH must be a power of two, at least 2");
        end
    end

    // =====================================================
    // Pin synchronisers and serial clock edge detection
    logic [`SADC_PIN_COUNT-1:0] pins_async;
    logic [`SADC_PIN_COUNT-1:0] pins_sync;
    logic sclk_prev_r;

    assign pins_async[`SADC_PIN_SCLK] = serial_clk_i;
    assign pins_async[`SADC_PIN_SEL] = sel_n_i;
    assign pins_async[`SADC_PIN_DIN] = serial_cmd_in_i;

    // Select resets to its idle high level, so no frame starts out of reset
    sadc_sync #(
        .WIDTH(`SADC_PIN_COUNT)
    ) u_sync (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .rst_val_i(`SADC_PIN_RST),
        .async_i(pins_async),
        .sync_o(pins_sync)
    );

    // Decoded pin events
    wire sclk_s = pins_sync[`SADC_PIN_SCLK];
    wire sel_n_s = pins_sync[`SADC_PIN_SEL];
    wire din_s = pins_sync[`SADC_PIN_DIN];
    wire sclk_rise = sclk_s && !sclk_prev_r;
    wire sclk_fall = !sclk_s && sclk_prev_r;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_prev_r <= sclk_s;
        end
    end

    // =====================================================
    // Sequencer state
    sadc_pkg::sadc_state_type state_r;
    sadc_pkg::sadc_state_type state_nxt;
    sadc_pkg::sadc_cfg_type cfg_r;
    sadc_pkg::sadc_cfg_type cfg_nxt;
    logic [RES_BITS-1:0] result_r;
    logic [RES_BITS-1:0] result_nxt;
    logic [IW-1:0] idx_r;
    logic [IW-1:0] idx_nxt;
    logic dout_r;
    logic dout_nxt;
    logic oe_n_r;
    logic oe_n_nxt;
    logic push_nxt;
    logic push_r;

    // One-hot weight of the bit under trial
    function automatic logic [RES_BITS-1:0] bit_weight(input logic [IW-1:0] idx);
        bit_weight = '0;
        bit_weight[idx] = 1'b1;
    endfunction : bit_weight

    // FIFO has room for the next word
    wire fifo_in_ready;

    // =====================================================
    // Named decodes used by the sequencer
    // Start bit is the first one seen on a rising clock
    wire start_seen = sclk_rise && din_s;
    // End points of the MSB-first and LSB-first phases
    wire last_decision = (idx_r == '0);
    wire last_lsb_bit = (idx_r == `SADC_IDX_MSB);
    // Neighbouring bit positions, cut back to the index width
    wire [IW-1:0] idx_down = IW'(idx_r - 1'b1);
    wire [IW-1:0] idx_up = IW'(idx_r + 1'b1);
    // Stored bit for the LSB-first phase
    wire lsb_first_bit = result_r[idx_r];

    // =====================================================
    // Next-state and output decisions
    always_comb begin
        state_nxt = state_r;
        cfg_nxt = cfg_r;
        result_nxt = result_r;
        idx_nxt = idx_r;
        dout_nxt = dout_r;
        oe_n_nxt = oe_n_r;
        push_nxt = 1'b0;
        if (sel_n_s) begin
            state_nxt = sadc_pkg::SADC_IDLE;
            oe_n_nxt = 1'b1;
            dout_nxt = 1'b0;
        end else begin
            case (state_r)
                // Select seen low: leave low power
                sadc_pkg::SADC_IDLE: begin
                    state_nxt = sadc_pkg::SADC_WAIT_START;
                    oe_n_nxt = 1'b1;
                end
                sadc_pkg::SADC_WAIT_START: begin
                    // Leading zeros are skipped
                    if (start_seen) begin
                        state_nxt = sadc_pkg::SADC_ADDR_MODE;
                    end
                end
                // Mode bit on the next rising clock
                sadc_pkg::SADC_ADDR_MODE: begin
                    if (sclk_rise) begin
                        cfg_nxt.single_or_diff_sel = din_s;
                        state_nxt = sadc_pkg::SADC_ADDR_POL;
                    end
                end
                // Polarity bit closes the address
                sadc_pkg::SADC_ADDR_POL: begin
                    if (sclk_rise) begin
                        cfg_nxt.odd_sign = din_s;
                        state_nxt = sadc_pkg::SADC_SETTLE;
                    end
                end
                sadc_pkg::SADC_SETTLE: begin
                    // Half a clock of settling, then drive a leading zero
                    if (sclk_fall) begin
                        oe_n_nxt = 1'b0;
                        dout_nxt = 1'b0;
                        result_nxt = `SADC_RESULT_RST;
                        idx_nxt = `SADC_IDX_MSB;
                        state_nxt = sadc_pkg::SADC_CONVERT;
                    end
                end
                sadc_pkg::SADC_CONVERT: begin
                    // One decision per falling edge, MSB first
                    if (sclk_fall) begin
                        result_nxt[idx_r] = cmp_i;
                        dout_nxt = cmp_i;
                        if (last_decision) begin
                            idx_nxt = `SADC_IDX_LSB_FIRST;
                            push_nxt = 1'b1;
                            state_nxt = sadc_pkg::SADC_LSB_OUT;
                        end else begin
                            idx_nxt = idx_down;
                        end
                    end
                end
                // Stored result again, LSB first, bit 0 skipped
                sadc_pkg::SADC_LSB_OUT: begin
                    if (sclk_fall) begin
                        dout_nxt = lsb_first_bit;
                        if (last_lsb_bit) begin
                            state_nxt = sadc_pkg::SADC_HOLD_LOW;
                        end else begin
                            idx_nxt = idx_up;
                        end
                    end
                end
                // Low until select returns high
                sadc_pkg::SADC_HOLD_LOW: begin
                    if (sclk_fall) begin
                        dout_nxt = 1'b0;
                    end
                end
                // Unused codes fall back to idle
                default: begin
                    state_nxt = sadc_pkg::SADC_IDLE;
                    oe_n_nxt = 1'b1;
                end
            endcase
        end
    end

    // =====================================================
    // Sequencer registers; once select is high they step to idle and then hold
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= sadc_pkg::SADC_IDLE;
            cfg_r <= '0;
            result_r <= `SADC_RESULT_RST;
            idx_r <= '0;
            dout_r <= 1'b0;
            oe_n_r <= 1'b1;
            push_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cfg_r <= cfg_nxt;
            result_r <= result_nxt;
            idx_r <= idx_nxt;
            dout_r <= dout_nxt;
            oe_n_r <= oe_n_nxt;
            push_r <= push_nxt;
        end
    end

    // =====================================================
    // Analog steering and trial level, taken from the next state so the flops line up with it
    sadc_pkg::sadc_mux_type mux_r;
    sadc_pkg::sadc_mux_type mux_nxt;
    logic [RES_BITS-1:0] dac_code_r;
    logic [RES_BITS-1:0] dac_code_nxt;
    wire next_is_convert = (state_nxt == sadc_pkg::SADC_CONVERT);

    assign mux_nxt.pos_is_ch1 = cfg_nxt.odd_sign;
    assign mux_nxt.neg_is_gnd = cfg_nxt.single_or_diff_sel;
    assign mux_nxt.neg_is_ch1 = !cfg_nxt.single_or_diff_sel && !cfg_nxt.odd_sign;
    // Trial level adds the weight of the bit under decision
    assign dac_code_nxt = next_is_convert ? (result_nxt | bit_weight(idx_nxt)) : result_nxt;

    // Steering and trial level registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mux_r <= `SADC_MUX_RST;
            dac_code_r <= `SADC_RESULT_RST;
        end else begin
            mux_r <= mux_nxt;
            dac_code_r <= dac_code_nxt;
        end
    end

    // Analog and status outputs
    assign mux_o = mux_r;
    assign dac_code_o = dac_code_r;
    assign sample_o = (state_r == sadc_pkg::SADC_SETTLE);
    assign low_power_o = (state_r == sadc_pkg::SADC_IDLE);

    // Serial output pins
    assign serial_out_o = dout_r;
    assign serial_out_oe_n_o = oe_n_r;

    // =====================================================
    // Result FIFO toward the parallel consumer
    sadc_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .in_valid_i(push_r),
        .in_ready_o(fifo_in_ready),
        .in_data_i(result_r),
        .out_valid_o(result_valid_o),
        .out_ready_i(result_ready_i),
        .out_data_o(result_o)
    );

    // A full FIFO drops the word; this shows the state to the system
    assign result_fifo_ready_o = fifo_in_ready;

endmodule : sadc_core

// ---- rtl/sadc_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides
module sadc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("sadc_fifo: DEPTH must be a power of two, at least 2");
        end
    end

    // Honest full and empty from the fill count
    assign in_ready_o = (count_r != DEPTH[PW:0]);
    assign out_valid_o = (count_r != '0);
    assign out_data_o = mem_r[rd_ptr_r];

    // =====================================================
    // Storage
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // =====================================================
    // Pointers and fill count
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= push ? PW'(wr_ptr_r + 1'b1) : wr_ptr_r;
            rd_ptr_r <= pop ? PW'(rd_ptr_r + 1'b1) : rd_ptr_r;
            count_r <= (PW + 1)'(count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
        end
    end

endmodule : sadc_fifo

// ---- rtl/sadc_pkg.sv ----
// Types shared by the serial converter control block
package sadc_pkg;

    // =====================================================
    // Sequence states, Gray coded along the normal path
    typedef enum logic [2:0] {
        SADC_IDLE = 3'h0,
        SADC_WAIT_START = 3'h1,
        SADC_ADDR_MODE = 3'h3,
        SADC_ADDR_POL = 3'h2,
        SADC_SETTLE = 3'h6,
        SADC_CONVERT = 3'h7,
        SADC_LSB_OUT = 3'h5,
        SADC_HOLD_LOW = 3'h4
    } sadc_state_type;

    // =====================================================
    // Input configuration chosen by the address bits
    typedef struct packed {
        logic single_or_diff_sel;
        logic odd_sign;
    } sadc_cfg_type;

    // =====================================================
    // Analog multiplexer steering
    typedef struct packed {
        logic pos_is_ch1;
        logic neg_is_gnd;
        logic neg_is_ch1;
    } sadc_mux_type;

endpackage : sadc_pkg

// ---- rtl/sadc_sync.sv ----
// Two-stage synchroniser for a group of pin inputs
module sadc_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] rst_val_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    initial begin
        if (WIDTH < 1) begin
            $error("sadc_sync: WIDTH must be at least 1");
        end
    end

    // =====================================================
    // Per-bit double flop; first stage feeds only the second
    // Flops hold the difference from the idle level, so reset shows that level
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_r[g] <= 1'b0;
                    sync_r[g] <= 1'b0;
                end else begin
                    meta_r[g] <= async_i[g] ^ rst_val_i[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_r ^ rst_val_i;

endmodule : sadc_sync

// ---- tb/sadc_checker.sv ----
// Port-level assertions of the serial converter control block
module sadc_checker #(
    parameter int RES_BITS = 8,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic serial_clk_i,
    input wire logic sel_n_i,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_n_o,
    input wire logic [RES_BITS-1:0] dac_code_o,
    input wire sadc_pkg::sadc_mux_type mux_o,
    input wire logic sample_o,
    input wire logic low_power_o,
    input wire logic result_valid_o,
    input wire logic result_ready_i,
    input wire logic [RES_BITS-1:0] result_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // Clocking and the settle window
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_settle;
        sample_o [*4];
    endsequence
    // ==========
    // Properties
    property p_idle_hiz;
        sel_n_i [*6] |-> serial_out_oe_n_o && low_power_o;
    endproperty
    property p_idle_static;
        low_power_o && $past(low_power_o) |-> $stable(dac_code_o) && $stable(mux_o);
    endproperty
    property p_word_stands;
        result_valid_o && !result_ready_i |=> result_valid_o && $stable(result_o);
    endproperty
    property p_abort;
        $rose(sel_n_i) |-> ##[1:6] serial_out_oe_n_o && low_power_o;
    endproperty
    property p_lead_zero;
        $fell(serial_out_oe_n_o) |-> !serial_out_o && !$past(serial_clk_i, 2) && !$past(sel_n_i, 4);
    endproperty
    property p_on_fall;
        $changed(serial_out_o) && !serial_out_oe_n_o |-> !$past(serial_clk_i, 2);
    endproperty
    property p_push_in_frame;
        $rose(result_valid_o) |-> $past(!serial_out_oe_n_o);
    endproperty
    property p_settle;
        $rose(sample_o) |-> serial_out_oe_n_o ##0 s_settle ##[1:8] !serial_out_oe_n_o;
    endproperty
    // ==========
    // Assertions
    a_idle_hiz: assert property (p_idle_hiz) else $error("output driven while deselected");
    a_idle_static: assert property (p_idle_static) else $error("logic moved in low power");
    a_word_stands: assert property (p_word_stands) else $error("result word lost");
    a_abort: assert property (p_abort) else $error("select high did not end frame");
    a_lead_zero: assert property (p_lead_zero) else $error("bad output enable");
    a_on_fall: assert property (p_on_fall) else $error("output moved off falling clock");
    a_push_in_frame: assert property (p_push_in_frame) else $error("word pushed outside frame");
    a_settle: assert property (p_settle) else $error("settle window wrong");
endmodule : sadc_checker

bind sadc_core sadc_checker #(.RES_BITS(RES_BITS), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .clock_i(clock_i), .rstn_i(rstn_i), .serial_clk_i(serial_clk_i), .sel_n_i(sel_n_i),
    .serial_out_o(serial_out_o), .serial_out_oe_n_o(serial_out_oe_n_o), .dac_code_o(dac_code_o),
    .mux_o(mux_o), .sample_o(sample_o), .low_power_o(low_power_o), .result_valid_o(result_valid_o),
    .result_ready_i(result_ready_i), .result_o(result_o));

// ---- tb/sadc_ctl_model.sv ----
// Controller and analog front-end model facing the converter block
module sadc_ctl_model (
    input wire logic clock_i,
    input wire logic serial_out_i,
    input wire logic serial_out_oe_n_i,
    input wire logic [7:0] dac_code_i,
    input wire sadc_pkg::sadc_mux_type mux_i,
    output logic serial_clk_o,
    output logic sel_n_o,
    output logic serial_cmd_in_o,
    output logic cmp_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 7;
    int ch0 = 0;
    int ch1 = 0;
    int pos, neg;
    logic drv = 1'b0;
    logic drv_en = 1'b1;
    logic got[$];
    // Serial clock stands low between frames
    initial begin
        serial_clk_o = 1'b0;
        sel_n_o = 1'b1;
        cmp_o = 1'b0;
    end
    // Shared wire: controller in address phase and between frames, else converter or a floating level
    assign serial_cmd_in_o = drv_en ? drv : (serial_out_oe_n_i ? ~drv : serial_out_i);
    // Comparator on the steered inputs; a negative difference never trips it
    always @(posedge clock_i) begin
        pos = mux_i.pos_is_ch1 ? ch1 : ch0;
        neg = mux_i.neg_is_gnd ? 0 : (mux_i.neg_is_ch1 ? ch1 : ch0);
        cmp_o <= (pos - neg) >= int'(dac_code_i);
    end
    task automatic hw(input int n);
        repeat (n) @(posedge clock_i);
    endtask : hw
    // One frame; a nonzero stop cuts it short before that clock
    task automatic run(input int z, input logic m, input logic p, input int stop);
        got.delete();
        hw(1);
        sel_n_o <= 1'b0;
        for (int n = 1; n <= z + 21 && n != stop; n++) begin
            drv_en <= n <= z + 3;
            drv <= n == z + 1 ? 1'b1 : n == z + 2 ? m : n == z + 3 ? p : 1'b0;
            hw(HALF);
            if (n > z + 3)
                got.push_back(serial_out_oe_n_i ? 1'bz : serial_out_i);
            serial_clk_o <= 1'b1;
            hw(HALF);
            serial_clk_o <= 1'b0;
        end
        hw(HALF);
        sel_n_o <= 1'b1;
        drv_en <= 1'b1;
        drv <= 1'b0;
        hw(8);
    endtask : run
endmodule : sadc_ctl_model

// ---- tb/serial_adc_conversion_interface_tb_top.sv ----
// Self-checking testbench of the serial converter control block
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module serial_adc_conversion_interface_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic result_ready_i = 1'b0;
    logic serial_clk, sel_n, cmd_in, cmp, s_out, s_oe_n, sample, low_power, r_valid, f_ready;
    logic [7:0] dac_code, r_data;
    sadc_pkg::sadc_mux_type mux;
    int mismatches = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h0000041C;
    int exp_q[$];
    // ==========
    // Design and partner
    sadc_core u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .serial_clk_i(serial_clk), .sel_n_i(sel_n),
        .serial_cmd_in_i(cmd_in), .serial_out_o(s_out), .serial_out_oe_n_o(s_oe_n), .cmp_i(cmp),
        .dac_code_o(dac_code), .mux_o(mux), .sample_o(sample), .low_power_o(low_power),
        .result_valid_o(r_valid), .result_ready_i(result_ready_i), .result_o(r_data),
        .result_fifo_ready_o(f_ready));
    sadc_ctl_model u_ctl (.clock_i(clock_i), .serial_out_i(s_out), .serial_out_oe_n_i(s_oe_n),
        .dac_code_i(dac_code), .mux_i(mux), .serial_clk_o(serial_clk), .sel_n_o(sel_n),
        .serial_cmd_in_o(cmd_in), .cmp_o(cmp));
    // Clock and hang guard
    initial forever #5 clock_i = ~clock_i;
    initial begin
        #1000000;
        mismatches++;
        print_verdict();
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // ==========
    // One conversion against the reference stream and word
    task automatic conv(input logic m, input logic p, input int c0, input int c1);
        int pos, neg, r, z;
        logic e;
        pos = p ? c1 : c0;
        neg = m ? 0 : (p ? c0 : c1);
        r = pos > neg ? pos - neg : 0;
        z = xs() % 3;
        u_ctl.ch0 = c0;
        u_ctl.ch1 = c1;
        fork
            u_ctl.run(z, m, p, 0);
            begin
                for (int i = 0; i < 400 && sample !== 1'b1; i++) @(posedge clock_i);
                `CHK("settle", 1'b1, sample)
                `CHK("addr_hiz", 1'b1, s_oe_n)
                `CHK("mux_pos", p, mux.pos_is_ch1)
                `CHK("mux_gnd", m, mux.neg_is_gnd)
                if (!m) `CHK("mux_neg", !p, mux.neg_is_ch1)
            end
        join
        `CHK("frame_len", 18, u_ctl.got.size())
        for (int i = 0; i < 18; i++) begin
            e = i == 0 || i > 15 ? 1'b0 : i < 9 ? r[8 - i] : r[i - 8];
            `CHK("serial_bit", e, u_ctl.got[i])
        end
        if (exp_q.size() < 4) exp_q.push_back(r);
        else `CHK("fifo_full", 1'b0, f_ready)
    endtask : conv
    // Drain the buffer with random stalls
    task automatic drain();
        int w;
        for (int i = 0; i < 300 && exp_q.size() > 0; i++) begin
            @(posedge clock_i);
            if (r_valid === 1'b1 && result_ready_i === 1'b1) begin
                w = exp_q.pop_front();
                `CHK("result", 8'(w), r_data)
            end
            result_ready_i <= 1'(xs() >> 3);
        end
        @(posedge clock_i);
        result_ready_i <= 1'b0;
        @(posedge clock_i);
        `CHK("drained", 0, exp_q.size())
        `CHK("empty", 1'b0, r_valid)
    endtask : drain
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // ==========
    // Main sequence
    initial begin
        int c0, c1;
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        `CHK("low_power", 1'b1, low_power)
        `CHK("oe_n", 1'b1, s_oe_n)
        `CHK("valid", 1'b0, r_valid)
        for (int k = 0; k < 5; k++) begin
            c0 = xs() % 256;
            c1 = k == 2 ? c0 / 2 + 128 : xs() % 256;
            conv(!k[1], k[0], c0, c1);
        end
        drain();
        u_ctl.run(0, 1'b1, 1'b1, 8);
        `CHK("abort_oe_n", 1'b1, s_oe_n)
        `CHK("abort_low_power", 1'b1, low_power)
        `CHK("abort_no_word", 1'b0, r_valid)
        conv(1'b0, 1'b1, 40, 200);
        drain();
        print_verdict();
    end
endmodule : serial_adc_conversion_interface_tb_top
